// [rtl/nvmcs_defines.svh]
// Function
// - Writing one to buffer-empty flag launches queued command and clears the flag.
// - Only burst program commands are buffered; flag re-sets when buffer frees.
// - Complete flag high when buffer empty and idle; cleared on launch; writes ignored.
// - Program or erase launch against protected location discards command and sets protection flag.
// - Broken command sequence sets access error and discards command.
// - Program or erase before divider written since reset sets access error.
// - Entering stop in busy state or with a burst queued sets access error.
// - Access error clears only on write of one; zero leaves it.
// - Blank check sets blank flag only if whole array reads erased.
// - Blank flag cleared on new valid launch; direct writes ignored.
// - Decoder knows blank check 05, byte program 20, burst program 25.
// - Decoder knows erase 40, mass erase 41, abort 47; others access error.
// - Mass erase refused when any sector is protected.
// - Successful program-memory blank check sets security field to 1:0.
`ifndef NVMCS_DEFINES_SVH
`define NVMCS_DEFINES_SVH
`define NVMCS_ADDR_STATUS 2'h0
`define NVMCS_ADDR_CODE 2'h1
`define NVMCS_ADDR_INT_MASK 2'h2
`define NVMCS_ADDR_INT_STATUS 2'h3
`define NVMCS_BIT_CBEF 7
`define NVMCS_BIT_CCF 6
`define NVMCS_BIT_PVIOL 5
`define NVMCS_BIT_ACCERR 4
`define NVMCS_BIT_BLANK 2
`define NVMCS_CMD_BLANK 8'h05
`define NVMCS_CMD_BYTE_PROG 8'h20
`define NVMCS_CMD_BURST_PROG 8'h25
`define NVMCS_CMD_SECTOR_ERASE 8'h40
`define NVMCS_CMD_MASS_ERASE 8'h41
`define NVMCS_CMD_ERASE_ABORT 8'h47
`define NVMCS_SEC_UNSECURED 2'h2
`define NVMCS_SEC_RESET 2'h3
`define NVMCS_CODE_RESET 8'h00
`define NVMCS_INT_DONE 0
`define NVMCS_INT_PVIOL 1
`define NVMCS_INT_ACCERR 2
`endif

// [rtl/nvmcs_pkg.sv]
package nvmcs_pkg;
  typedef enum logic [2:0] {
    NVMCS_CMD_NONE,
    NVMCS_CMD_BLANK_CHECK,
    NVMCS_CMD_BYTE,
    NVMCS_CMD_BURST,
    NVMCS_CMD_SECTOR,
    NVMCS_CMD_MASS,
    NVMCS_CMD_ABORT
  } nvmcs_cmd_t;
  typedef enum {
    NVMCS_IDLE,
    NVMCS_ARMED,
    NVMCS_BUSY
  } nvmcs_state_t;
endpackage

// [rtl/nvmcs_decoder.sv]
`timescale 1ns/1ns
`include "nvmcs_defines.svh"
module nvmcs_decoder
  import nvmcs_pkg::*;
(
  // Command code
  input wire logic [7:0] code_in,
  // Decoded kind
  output nvmcs_cmd_t kind_out,
  output logic valid_out,
  output logic alters_out
);
  always_comb begin
    case (code_in)
      `NVMCS_CMD_BLANK: kind_out = NVMCS_CMD_BLANK_CHECK;
      `NVMCS_CMD_BYTE_PROG: kind_out = NVMCS_CMD_BYTE;
      `NVMCS_CMD_BURST_PROG: kind_out = NVMCS_CMD_BURST;
      `NVMCS_CMD_SECTOR_ERASE: kind_out = NVMCS_CMD_SECTOR;
      `NVMCS_CMD_MASS_ERASE: kind_out = NVMCS_CMD_MASS;
      `NVMCS_CMD_ERASE_ABORT: kind_out = NVMCS_CMD_ABORT;
      default: kind_out = NVMCS_CMD_NONE;
    endcase
    valid_out = (kind_out != NVMCS_CMD_NONE);
    // Abort and blank check change no array data
    alters_out = valid_out && (kind_out != NVMCS_CMD_BLANK_CHECK) && (kind_out != NVMCS_CMD_ABORT);
  end
endmodule // nvmcs_decoder

// [rtl/nvmcs_core.sv]
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "nvmcs_defines.svh"
module nvmcs_core
  import nvmcs_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Register port
  input wire logic [1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  // Array-side command data write and system events
  input wire logic array_write_in,
  input wire logic divider_written_in,
  input wire logic stop_entry_in,
  input wire logic target_protected_in,
  input wire logic any_sector_protected_in,
  input wire logic target_is_program_mem_in,
  // Array handshake
  output logic array_start_out,
  output logic [7:0] array_cmd_out,
  input wire logic array_done_in,
  input wire logic array_blank_in,
  // Status outputs
  output logic [1:0] security_state_field_out,
  output logic irq_out
);
  nvmcs_state_t state_reg, state_next;
  logic cbef_reg, cbef_next;
  logic pviol_reg, pviol_next;
  logic accerr_reg, accerr_next;
  logic blank_reg, blank_next;
  logic queued_reg, queued_next;
  logic busy_burst_reg, busy_burst_next;
  logic busy_blank_reg, busy_blank_next;
  logic busy_prog_reg, busy_prog_next;
  logic div_seen_reg, div_seen_next;
  logic [7:0] code_reg, code_next;
  logic [7:0] array_cmd_reg, array_cmd_next;
  logic start_reg, start_next;
  logic [1:0] sec_reg, sec_next;
  logic [2:0] int_mask_reg, int_mask_next;
  logic [2:0] int_stat_reg, int_stat_next;
  logic [7:0] rdata_reg, rdata_next;
  logic ccf_reg, ccf_next;
  nvmcs_cmd_t kind;
  logic kind_valid;
  logic kind_alters;
  logic wr_status;
  logic wr_code;
  logic launch;
  logic [7:0] status_view;

  nvmcs_decoder u_decoder (
    .code_in(code_reg),
    .kind_out(kind),
    .valid_out(kind_valid),
    .alters_out(kind_alters)
  );

  assign wr_status = reg_write_in && (reg_addr_in == `NVMCS_ADDR_STATUS);
  assign wr_code = reg_write_in && (reg_addr_in == `NVMCS_ADDR_CODE);
  assign launch = wr_status && reg_wdata_in[`NVMCS_BIT_CBEF] && cbef_reg;

  always_comb begin
    status_view = 8'h00;
    status_view[`NVMCS_BIT_CBEF] = cbef_reg;
    status_view[`NVMCS_BIT_CCF] = ccf_reg;
    status_view[`NVMCS_BIT_PVIOL] = pviol_reg;
    status_view[`NVMCS_BIT_ACCERR] = accerr_reg;
    status_view[`NVMCS_BIT_BLANK] = blank_reg;
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    cbef_next = cbef_reg;
    pviol_next = pviol_reg;
    accerr_next = accerr_reg;
    blank_next = blank_reg;
    queued_next = queued_reg;
    busy_burst_next = busy_burst_reg;
    busy_blank_next = busy_blank_reg;
    busy_prog_next = busy_prog_reg;
    div_seen_next = div_seen_reg || divider_written_in;
    code_next = code_reg;
    array_cmd_next = array_cmd_reg;
    start_next = 1'b0;
    sec_next = sec_reg;
    // Clears first so that a hardware set in the same cycle wins
    if (wr_status && reg_wdata_in[`NVMCS_BIT_PVIOL]) begin
      pviol_next = 1'b0;
    end
    if (wr_status && reg_wdata_in[`NVMCS_BIT_ACCERR]) begin
      accerr_next = 1'b0;
    end
    // Completion is taken in BUSY, or in any state while a burst runs: a burst may end while the next one is armed
    if (array_done_in && (state_reg == NVMCS_BUSY || busy_burst_reg)) begin
      if (queued_reg) begin
        queued_next = 1'b0;
        start_next = 1'b1;
        cbef_next = 1'b1;
        if (state_reg == NVMCS_IDLE) begin
          state_next = NVMCS_BUSY;
        end
      end else begin
        if (busy_blank_reg && array_blank_in) begin
          blank_next = 1'b1;
          if (busy_prog_reg) begin
            sec_next = `NVMCS_SEC_UNSECURED;
          end
        end
        busy_burst_next = 1'b0;
        busy_blank_next = 1'b0;
        cbef_next = 1'b1;
        if (state_reg == NVMCS_BUSY) begin
          state_next = NVMCS_IDLE;
        end
      end
    end
    case (state_reg)
      NVMCS_IDLE: begin
        if (array_write_in) begin
          state_next = NVMCS_ARMED;
        end else if (wr_code || launch) begin
          accerr_next = 1'b1;
        end
      end
      NVMCS_ARMED: begin
        if (wr_code) begin
          code_next = reg_wdata_in;
        end else if (launch) begin
          state_next = NVMCS_IDLE;
          if (!kind_valid) begin
            accerr_next = 1'b1;
          end else if (kind_alters && !div_seen_reg) begin
            accerr_next = 1'b1;
          end else if (kind == NVMCS_CMD_MASS && any_sector_protected_in) begin
            pviol_next = 1'b1;
          end else if (kind_alters && kind != NVMCS_CMD_MASS && target_protected_in) begin
            pviol_next = 1'b1;
          end else if (busy_blank_next || (busy_burst_next && kind != NVMCS_CMD_BURST)) begin
            accerr_next = 1'b1;
          end else begin
            blank_next = 1'b0;
            cbef_next = 1'b0;
            if (busy_burst_next) begin
              queued_next = 1'b1;
            end else begin
              start_next = 1'b1;
              array_cmd_next = code_reg;
              busy_burst_next = (kind == NVMCS_CMD_BURST);
              busy_blank_next = (kind == NVMCS_CMD_BLANK_CHECK);
              busy_prog_next = target_is_program_mem_in;
              cbef_next = (kind == NVMCS_CMD_BURST);
              state_next = NVMCS_BUSY;
            end
          end
        end else if (reg_write_in || array_write_in) begin
          state_next = NVMCS_IDLE;
          accerr_next = 1'b1;
        end
      end
      NVMCS_BUSY: begin
        if (array_write_in && busy_burst_reg && !queued_reg) begin
          state_next = NVMCS_ARMED;
        end else if (launch || wr_code) begin
          accerr_next = 1'b1;
        end
      end
      default: state_next = NVMCS_IDLE;
    endcase
    if (stop_entry_in && (state_reg == NVMCS_BUSY || queued_reg)) begin
      accerr_next = 1'b1;
    end
  end

  // Done when buffer empty and no array operation outstanding
  always_comb begin
    ccf_next = cbef_next && !busy_burst_next && !busy_blank_next && !start_next
      && (state_next != NVMCS_BUSY);
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    int_mask_next = int_mask_reg;
    int_stat_next = int_stat_reg;
    rdata_next = 8'h00;
    if (reg_write_in && reg_addr_in == `NVMCS_ADDR_INT_MASK) begin
      int_mask_next = reg_wdata_in[2:0];
    end
    if (reg_write_in && reg_addr_in == `NVMCS_ADDR_INT_STATUS) begin
      int_stat_next = int_stat_reg & ~reg_wdata_in[2:0];
    end
    // Sets after clears: an event never lost on clear
    if (ccf_next && !ccf_reg) begin
      int_stat_next[`NVMCS_INT_DONE] = 1'b1;
    end
    if (pviol_next && !pviol_reg) begin
      int_stat_next[`NVMCS_INT_PVIOL] = 1'b1;
    end
    if (accerr_next && !accerr_reg) begin
      int_stat_next[`NVMCS_INT_ACCERR] = 1'b1;
    end
    if (reg_read_in) begin
      case (reg_addr_in)
        `NVMCS_ADDR_STATUS: rdata_next = status_view;
        `NVMCS_ADDR_CODE: rdata_next = code_reg;
        `NVMCS_ADDR_INT_MASK: rdata_next = {5'h00, int_mask_reg};
        `NVMCS_ADDR_INT_STATUS: rdata_next = {5'h00, int_stat_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_reg <= NVMCS_IDLE;
      cbef_reg <= 1'b1;
      ccf_reg <= 1'b1;
      pviol_reg <= 1'b0;
      accerr_reg <= 1'b0;
      blank_reg <= 1'b0;
      queued_reg <= 1'b0;
      busy_burst_reg <= 1'b0;
      busy_blank_reg <= 1'b0;
      busy_prog_reg <= 1'b0;
      div_seen_reg <= 1'b0;
      code_reg <= `NVMCS_CODE_RESET;
      array_cmd_reg <= `NVMCS_CODE_RESET;
      start_reg <= 1'b0;
      sec_reg <= `NVMCS_SEC_RESET;
      int_mask_reg <= 3'h0;
      int_stat_reg <= 3'h0;
      rdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      cbef_reg <= cbef_next;
      ccf_reg <= ccf_next;
      pviol_reg <= pviol_next;
      accerr_reg <= accerr_next;
      blank_reg <= blank_next;
      queued_reg <= queued_next;
      busy_burst_reg <= busy_burst_next;
      busy_blank_reg <= busy_blank_next;
      busy_prog_reg <= busy_prog_next;
      div_seen_reg <= div_seen_next;
      code_reg <= code_next;
      array_cmd_reg <= array_cmd_next;
      start_reg <= start_next;
      sec_reg <= sec_next;
      int_mask_reg <= int_mask_next;
      int_stat_reg <= int_stat_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign array_start_out = start_reg;
  assign array_cmd_out = array_cmd_reg;
  assign security_state_field_out = sec_reg;
  assign irq_out = |(int_stat_reg & int_mask_reg);
endmodule // nvmcs_core

// [tb/nvmcs_core_props.sv]
`timescale 1ns/1ns
`include "nvmcs_defines.svh"
module nvmcs_core_props (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Register port
  input wire logic [1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  // Array side
  input wire logic divider_written_in,
  input wire logic target_protected_in,
  input wire logic any_sector_protected_in,
  input wire logic array_start_out,
  input wire logic [7:0] array_cmd_out,
  input wire logic array_done_in,
  input wire logic [1:0] security_state_field_out
);
  logic [7:0] code_reg = 8'h00;
  logic div_reg = 1'b0;
  logic go;
  logic alt;
  // Done in the same cycle may start a queued burst, so it is excluded
  assign go = reg_write_in && reg_addr_in == 2'h0 && reg_wdata_in[7] && !array_done_in;
  assign alt = code_reg inside {8'h20, 8'h25, 8'h40, 8'h41};
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      code_reg <= 8'h00;
      div_reg <= 1'b0;
    end else begin
      if (reg_write_in && reg_addr_in == 2'h1)
        code_reg <= reg_wdata_in;
      if (divider_written_in)
        div_reg <= 1'b1;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_start_cause: assert property (array_start_out |-> $past(go) || $past(array_done_in))
    else $error("start without launch or completion");
  a_rdata_idle: assert property (!$past(reg_read_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside answer cycle");
  a_status_spare: assert property ($past(reg_read_in && reg_addr_in == 2'h0)
    |-> reg_rdata_out[3] == 1'b0 && reg_rdata_out[1:0] == 2'b00)
    else $error("spare status bits not zero");
  a_sec_unlock: assert property ($changed(security_state_field_out)
    |-> security_state_field_out == `NVMCS_SEC_UNSECURED && $past(array_done_in))
    else $error("security field changed wrongly");
  a_cmd_legal: assert property (array_start_out
    |-> array_cmd_out inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h47})
    else $error("illegal command started");
  a_protect_drop: assert property (go && target_protected_in && alt |=> !array_start_out)
    else $error("protected command started");
  a_code_drop: assert property (go && !(code_reg inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41,
    8'h47}) |=> !array_start_out)
    else $error("invalid code started");
  a_mass_drop: assert property (go && code_reg == 8'h41 && any_sector_protected_in
    |=> !array_start_out)
    else $error("mass erase with protection started");
  a_div_drop: assert property (go && alt && !div_reg |=> !array_start_out)
    else $error("alteration before divider set");
endmodule // nvmcs_core_props
bind nvmcs_core nvmcs_core_props u_props (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .divider_written_in(divider_written_in), .target_protected_in(target_protected_in),
  .any_sector_protected_in(any_sector_protected_in), .array_start_out(array_start_out),
  .array_cmd_out(array_cmd_out), .array_done_in(array_done_in),
  .security_state_field_out(security_state_field_out));

// [tb/nvmcs_array_model.sv]
`timescale 1ns/1ns
module nvmcs_array_model (
  // Clock
  input wire logic clk_in,
  // Command handshake
  input wire logic start_in,
  input wire logic slow_in,
  input wire logic erased_in,
  output logic done_out,
  output logic blank_out
);
  logic [4:0] cnt_reg = 5'h00;
  assign done_out = cnt_reg == 5'h01;
  // Inverted outside done so a stale level is never trusted
  assign blank_out = done_out ? erased_in : !erased_in;
  always_ff @(posedge clk_in) begin
    if (start_in) begin
      cnt_reg <= slow_in ? 5'h14 : 5'h03;
    end else if (cnt_reg != 5'h00) begin
      cnt_reg <= cnt_reg - 5'h01;
    end
  end
endmodule // nvmcs_array_model

// [tb/nvmcs_core_tb.sv]
`timescale 1ns/1ns
`include "nvmcs_defines.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module nvmcs_core_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic we = 1'b0, re = 1'b0, aw = 1'b0, divw = 1'b0, stop = 1'b0;
  logic tprot = 1'b0, aprot = 1'b0, prog = 1'b1, slow = 1'b0, erased = 1'b1;
  logic [7:0] rdata, cmd;
  logic [1:0] sec;
  logic start, done, blank, irq;
  int err_count = 0;
  int compares = 0;
  logic [7:0] codes [6] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h47};
  nvmcs_core DUT (.clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(we), .reg_read_in(re), .reg_rdata_out(rdata),
    .array_write_in(aw), .divider_written_in(divw), .stop_entry_in(stop),
    .target_protected_in(tprot), .any_sector_protected_in(aprot),
    .target_is_program_mem_in(prog), .array_start_out(start), .array_cmd_out(cmd),
    .array_done_in(done), .array_blank_in(blank), .security_state_field_out(sec),
    .irq_out(irq));
  nvmcs_array_model u_array (.clk_in(clk), .start_in(start), .slow_in(slow),
    .erased_in(erased), .done_out(done), .blank_out(blank));
  initial begin
    forever #25 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic launch(input logic [7:0] c, input logic s);
    @(posedge clk);
    aw <= 1'b1;
    @(posedge clk);
    aw <= 1'b0;
    wr(2'h1, c);
    wr(2'h0, 8'h80);
    #1;
    `CHK(start, s)
    if (s)
      `CHK(cmd, c)
  endtask
  task automatic finish_op(input logic [7:0] e);
    int i;
    i = 0;
    // Look just after the edge so the model's counter has settled
    while (i < 40 && done !== 1'b1) begin
      @(posedge clk);
      #1;
      i++;
    end
    `CHK(done, 1'b1)
    rd(2'h0, e);
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Tests need well under 1000 cycles; ten times that means a hang
  initial begin
    #500000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(2'h0, 8'hC0);
    `CHK(sec, `NVMCS_SEC_RESET)
    launch(8'h20, 1'b0);
    rd(2'h0, 8'hD0);
    wr(2'h0, 8'h4F);
    rd(2'h0, 8'hD0);
    wr(2'h0, 8'h10);
    rd(2'h0, 8'hC0);
    $display("test divider done");
    @(posedge clk);
    divw <= 1'b1;
    @(posedge clk);
    divw <= 1'b0;
    foreach (codes[i]) begin
      launch(codes[i], 1'b1);
      rd(2'h0, codes[i] == 8'h25 ? 8'h80 : 8'h00);
      finish_op(codes[i] == 8'h05 ? 8'hC4 : 8'hC0);
    end
    `CHK(sec, `NVMCS_SEC_UNSECURED)
    $display("test codes done");
    tprot <= 1'b1;
    launch(8'h40, 1'b0);
    tprot <= 1'b0;
    rd(2'h0, 8'hE0);
    aprot <= 1'b1;
    launch(8'h41, 1'b0);
    aprot <= 1'b0;
    wr(2'h0, 8'h30);
    launch(8'h33, 1'b0);
    rd(2'h0, 8'hD0);
    wr(2'h0, 8'h10);
    wr(2'h1, 8'h20);
    rd(2'h0, 8'hD0);
    wr(2'h0, 8'h10);
    $display("test refusals done");
    slow <= 1'b1;
    launch(8'h40, 1'b1);
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    rd(2'h0, 8'h10);
    finish_op(8'hD0);
    wr(2'h0, 8'h10);
    launch(8'h25, 1'b1);
    launch(8'h25, 1'b0);
    rd(2'h0, 8'h00);
    finish_op(8'h80);
    finish_op(8'hC0);
    $display("test stop and burst done");
    wr(2'h2, 8'h00);
    #1;
    `CHK(irq, 1'b0)
    wr(2'h2, 8'h07);
    #1;
    `CHK(irq, 1'b1)
    wr(2'h3, 8'h07);
    rd(2'h3, 8'h00);
    `CHK(irq, 1'b0)
    $display("test interrupts done");
    complete_run();
  end
endmodule // nvmcs_core_tb
